// ==== pkg/oamx_defines.svh ====
/*
 Timing-free constants for the OR / move / literal-load execute block:
 opcode patterns, field positions and reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
// Notes on behaviour
// - Upper nibble 1101 is literal-OR; low byte is literal 0 to 255.
// - Literal-OR ORs accumulator with literal into accumulator; zero flag follows.
// - Prefix 0001 00 is register-OR; bit 5 selects destination, low five address.
// - Register-OR with destination clear writes accumulator and updates zero flag.
// - Register-OR with destination set writes file register; zero flag still updated.
// - Prefix 0010 00 is register-move, same fields, reads addressed file register.
// - Register-move copies file register to accumulator, or back to itself.
// - Register-move always updates zero flag, even with destination set.
`ifndef OAMX_DEFINES_SVH
`define OAMX_DEFINES_SVH

`define OAMX_OP_IORL    4'hD
`define OAMX_OP_LDL     4'hC
`define OAMX_OP_IORF    6'h04
`define OAMX_OP_MVF     6'h08
`define OAMX_NIB_MSB    11
`define OAMX_NIB_LSB    8
`define OAMX_PFX_LSB    6
`define OAMX_DEST_BIT   5
`define OAMX_ADDR_MSB   4
`define OAMX_LIT_MSB    7
`define OAMX_ACC_RST    8'h00
`define OAMX_Z_RST      1'b0
`define OAMX_FREG_RST   8'h00
`define OAMX_NUM_FREG   32

`endif

// ==== pkg/oamx_pkg.sv ====
/*
 Types for the execute block.
 Assumes oamx_defines.svh is on the include path.
*/
`include "oamx_defines.svh"
package oamx_pkg;
   typedef enum logic [4:0] {
      OAMX_NONE = 5'h01,
      OAMX_IORL = 5'h02,
      OAMX_IORF = 5'h04,
      OAMX_MVF  = 5'h08,
      OAMX_LDL  = 5'h10
   } oamx_op_t;
endpackage : oamx_pkg

// ==== src/oamx_decode.sv ====
/*
 Instruction decoder: classifies a 12-bit word into one operation.
 Assumes a stable word from fetch in the same clock domain.
*/
`include "oamx_defines.svh"
module oamx_decode
   import oamx_pkg::*;
(
   // Word in
   input  wire logic [11:0] instr_i,
   // Class out
   output oamx_op_t         op_o
);

   wire [3:0] nib = instr_i[`OAMX_NIB_MSB:`OAMX_NIB_LSB];
   wire [5:0] pfx = instr_i[`OAMX_NIB_MSB:`OAMX_PFX_LSB];

   wire is_iorl = (nib == `OAMX_OP_IORL);
   wire is_ldl  = (nib == `OAMX_OP_LDL);
   wire is_iorf = (pfx == `OAMX_OP_IORF);
   wire is_mvf  = (pfx == `OAMX_OP_MVF);

   assign op_o = is_iorl ? OAMX_IORL :
                 is_ldl  ? OAMX_LDL  :
                 is_iorf ? OAMX_IORF :
                 is_mvf  ? OAMX_MVF  : OAMX_NONE;

endmodule : oamx_decode

// ==== src/oamx_exec.sv ====
/*
 Execute stage for literal-OR, register-OR, register-move and
 literal-load. Holds the accumulator, zero flag and 32 file registers.
 Assumes fetch presents one word per cycle with a valid strobe on MCLK_I.
*/
`include "oamx_defines.svh"
module oamx_exec
   import oamx_pkg::*;
(
   // Clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RST_N_I,
   // Instruction from fetch
   input  wire logic        INSTR_VALID_I,
   input  wire logic [11:0] INSTR_I,
   // Architectural state
   output logic      [7:0]  ACC_O,
   output logic             ZERO_O,
   output logic             DONE_O,
   output logic             ILLEGAL_O
);

   ////////////////////////////////////////////////////////////////////
   oamx_op_t   op;
   logic [7:0] acc_ff;
   logic       z_ff;
   logic       done_ff;
   logic       ill_ff;
   logic [7:0] freg_ff [`OAMX_NUM_FREG];

   oamx_decode u_dec (
      .instr_i (INSTR_I),
      .op_o    (op)
   );

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction : is_zero

   ////////////////////////////////////////////////////////////////////
   wire [7:0] lit  = INSTR_I[`OAMX_LIT_MSB:0];
   wire [4:0] addr = INSTR_I[`OAMX_ADDR_MSB:0];
   wire       dest = INSTR_I[`OAMX_DEST_BIT];
   wire [7:0] fval = freg_ff[addr];
   wire       go   = INSTR_VALID_I;

   wire [7:0] or_lit = acc_ff | lit;
   wire [7:0] or_reg = acc_ff | fval;

   logic [7:0] res;
   logic       wr_acc;
   logic       wr_f;
   logic       wr_z;

   always_comb begin
      res    = 8'h00;
      wr_acc = 1'b0;
      wr_f   = 1'b0;
      wr_z   = 1'b0;
      case (op)
         OAMX_IORL: begin
            res    = or_lit;
            wr_acc = go;
            wr_z   = go;
         end
         OAMX_IORF: begin
            res    = or_reg;
            wr_acc = go & ~dest;
            wr_f   = go & dest;
            wr_z   = go;
         end
         OAMX_MVF: begin
            res    = fval;
            wr_acc = go & ~dest;
            wr_f   = go & dest;
            wr_z   = go;
         end
         OAMX_LDL: begin
            res    = lit;
            wr_acc = go;
         end
         default: begin
            res    = 8'h00;
         end
      endcase
   end

   wire [7:0] nxt_acc_ff = wr_acc ? res : acc_ff;
   wire       nxt_z_ff   = wr_z ? is_zero(res) : z_ff;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         acc_ff  <= `OAMX_ACC_RST;
         z_ff    <= `OAMX_Z_RST;
         done_ff <= 1'b0;
         ill_ff  <= 1'b0;
      end else begin
         acc_ff  <= nxt_acc_ff;
         z_ff    <= nxt_z_ff;
         done_ff <= go & (op != OAMX_NONE);
         ill_ff  <= go & (op == OAMX_NONE);
      end
   end

   // File registers; write-back of same value is harmless for move
   genvar gi;
   generate
      for (gi = 0; gi < `OAMX_NUM_FREG; gi++) begin : g_freg
         always_ff @(posedge MCLK_I) begin
            if (!RST_N_I) begin
               freg_ff[gi] <= `OAMX_FREG_RST;
            end else if (wr_f && addr == 5'(gi)) begin
               freg_ff[gi] <= res;
            end
         end
      end
   endgenerate

   assign ACC_O     = acc_ff;
   assign ZERO_O    = z_ff;
   assign DONE_O    = done_ff;
   assign ILLEGAL_O = ill_ff;

endmodule : oamx_exec

// ==== bench/oamx_exec_properties.sv ====
/* Port checker for oamx_exec.
 Assumes it is bound onto the design from the bench top file. */
module oamx_exec_chk (
   input wire logic        MCLK_I,
   input wire logic        RST_N_I,
   input wire logic        INSTR_VALID_I,
   input wire logic [11:0] INSTR_I,
   input wire logic [7:0]  ACC_O,
   input wire logic        ZERO_O,
   input wire logic        DONE_O,
   input wire logic        ILLEGAL_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   wire       v = INSTR_VALID_I;
   wire [3:0] n = INSTR_I[11:8];
   wire       f = INSTR_I[11:6] == 6'h04 || INSTR_I[11:6] == 6'h08;
   wire       ok = n == 4'hD || n == 4'hC || f;
   wire       d = INSTR_I[5];
   ////////////////////////////////////////
   lit_or_a: assert property (v && n == 4'hD |=>
      ACC_O == ($past(ACC_O) | $past(INSTR_I[7:0])) && ZERO_O == !ACC_O)
      else $error("or literal bad");
   lit_load_a: assert property (v && n == 4'hC |=>
      ACC_O == $past(INSTR_I[7:0]) && $stable(ZERO_O)) else $error("load bad");
   reg_zero_a: assert property (v && f && !d |=> ZERO_O == !ACC_O)
      else $error("zero bad");
   acc_kept_a: assert property (v && f && d |=> $stable(ACC_O))
      else $error("acc changed");
   done_pulse_a: assert property (DONE_O == $past(v && ok))
      else $error("done bad");
   illegal_a: assert property (v && !ok |=>
      ILLEGAL_O && $stable(ACC_O)) else $error("illegal bad");
   ill_cause_a: assert property (ILLEGAL_O |-> $past(v && !ok))
      else $error("stray illegal");
   idle_hold_a: assert property (!v |=> $stable({ACC_O, ZERO_O}))
      else $error("idle change");
endmodule : oamx_exec_chk

// ==== bench/test_oamx_exec.sv ====
/* Bench for oamx_exec: literal, register and illegal words.
 Assumes package, design and checker are compiled first. */
module test_oamx_exec;
   timeunit 1ns;
   timeprecision 1ns;
   logic        MCLK_I = 1'b0;
   logic        RST_N_I = 1'b0;
   logic        INSTR_VALID_I = 1'b0;
   logic [11:0] INSTR_I = 12'h000;
   logic [7:0]  ACC_O;
   logic        ZERO_O, DONE_O, ILLEGAL_O;
   int          num_errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   oamx_exec dut (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
      .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .ACC_O(ACC_O),
      .ZERO_O(ZERO_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O));
   initial forever #5 MCLK_I = ~MCLK_I;
   always @(posedge MCLK_I) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         num_errors++;
         end_of_test();
      end
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task ex(input logic [11:0] w);
      @(negedge MCLK_I);
      INSTR_VALID_I = 1'b1;
      INSTR_I = w;
      @(negedge MCLK_I);
      INSTR_VALID_I = 1'b0;
   endtask : ex
   ////////////////////////////////////////
   task t_lit();
      ex(12'hC9A);
      ex(12'hD35);
      chk(ACC_O, 8'hBF);
      chk(8'(ZERO_O), 8'h00);
      ex(12'hC00);
      ex(12'hD00);
      chk(8'(DONE_O), 8'h01);
      chk(8'(ZERO_O), 8'h01);
      // Loads keep Z, so the stale set flag must survive
      ex(12'hC5A);
      chk(8'(ZERO_O), 8'h01);
      chk(ACC_O, 8'h5A);
   endtask : t_lit
   task t_reg();
      ex(12'hC13);
      ex(12'h13F);
      chk(ACC_O, 8'h13);
      chk(8'(ZERO_O), 8'h00);
      ex(12'hC80);
      ex(12'h11F);
      chk(ACC_O, 8'h93);
      ex(12'h21F);
      chk(ACC_O, 8'h13);
      ex(12'h220);
      chk(8'(ZERO_O), 8'h01);
      chk(ACC_O, 8'h13);
   endtask : t_reg
   task t_ill();
      ex(12'h140);
      chk(8'(ILLEGAL_O), 8'h01);
      ex(12'h260);
      chk(8'(DONE_O), 8'h00);
      chk(ACC_O, 8'h13);
   endtask : t_ill
   task end_of_test();
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (2) @(negedge MCLK_I);
      RST_N_I = 1'b1;
      chk(ACC_O, 8'h00);
      t_lit();
      t_reg();
      t_ill();
      end_of_test();
   end
endmodule : test_oamx_exec
bind oamx_exec oamx_exec_chk chk_i (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
   .INSTR_VALID_I(INSTR_VALID_I), .INSTR_I(INSTR_I), .ACC_O(ACC_O),
   .ZERO_O(ZERO_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O));
